// ===== logic/sac_conversion_control.sv
// Operation
// - enable bit clear puts converter in shutdown, no conversions.
// - enable bit set makes converter active and accepting start triggers.
// - normal track mode tracks continuously except while converting.
// - low-power track mode tracks as the start-mode field dictates.
// - done flag is set when busy falls at conversion end.
// - busy bit reads 1 during timed low-power tracking and conversion, else 0 (0 while tracking with pin low in mode 010).
// - busy write 1 starts only with start mode 000; write 0 ignored.
// - normal mode, start mode 001: timer 3 overflow starts conversion.
// - normal mode, start mode 010: rising external start pin starts it.
// - normal mode, start mode 011: timer 2 overflow starts conversion.
// - normal mode, start mode 1xx: companion busy write starts it.
// - low-power, mode 000: busy write gives 3 sar clocks tracking, convert.
// - low-power, mode 001: timer 3 overflow gives 3 clocks tracking, convert.
// - low-power, mode 010: track while pin low, convert on its rise.
// - low-power, mode 011: timer 2 overflow gives 3 clocks tracking, convert.
// - low-power, mode 1xx: companion write gives 3 clocks tracking, convert.
// - window flag sets on window match and stays until cleared.
`timescale 1ns/10ps
`default_nettype none

module sac_conversion_control #(
	parameter int SAR_DIV = sac_pkg::SAR_DIV_DEFAULT,
	parameter int CONV_CLOCKS = sac_pkg::CONV_SAR_CLOCKS
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [sac_pkg::ADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// start sources
	input wire logic timer3Overflow,
	input wire logic timer2Overflow,
	input wire logic companionBusyWrite,
	input wire logic extConvertStart,
	// result side
	input wire logic windowMatch,
	input wire logic [2:0] channelSel,
	output logic resultTwosComp,
	// analog control
	output sac_pkg::sac_analog_s analog,
	output logic [sac_pkg::PAIR_COUNT-1:0] pairDiff,
	output logic convDonePulse
);

	localparam int CNT_W = 8;
	localparam logic [CNT_W-1:0] TRACK_LAST =
		CNT_W'(sac_pkg::TRACK_SAR_CLOCKS - 1);
	localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CLOCKS - 1);
	localparam logic [CNT_W-1:0] DIV_LAST = CNT_W'(SAR_DIV - 1);

	// ==========================================================
	// bus data phase
	logic dphWrite, next_dphWrite;
	logic [sac_pkg::ADDR_W-1:0] dphAddr, next_dphAddr;
	logic [31:0] next_hrdata;
	logic addrPhase;

	sac_pkg::sac_ctrl_s ctrl, next_ctrl;
	logic [sac_pkg::PAIR_COUNT-1:0] next_pairDiff;
	logic doneFlag, next_doneFlag;
	logic windowFlag, next_windowFlag;
	sac_pkg::sac_state_e state, next_state;
	logic busy;

	assign addrPhase = hsel && hready && htrans == sac_pkg::HTRANS_NONSEQ;
	assign hreadyout = 1'b1;
	assign hresp = sac_pkg::HRESP_OKAY;

	always_comb begin
		next_dphWrite = dphWrite;
		next_dphAddr = dphAddr;
		next_hrdata = hrdata;
		if (hready) begin
			next_dphWrite = addrPhase && hwrite;
			next_dphAddr = haddr;
			next_hrdata = '0;
			if (addrPhase && !hwrite) begin
				case (haddr)
					sac_pkg::ADDR_PAIR_CFG: begin
						next_hrdata[sac_pkg::PAIR_COUNT-1:0] = pairDiff;
					end
					sac_pkg::ADDR_CONTROL: begin
						next_hrdata[sac_pkg::BIT_CONV_ENABLE] = ctrl.convEnable;
						next_hrdata[sac_pkg::BIT_TRACK_MODE] = ctrl.trackModeSel;
						next_hrdata[sac_pkg::BIT_DONE_FLAG] = doneFlag;
						next_hrdata[sac_pkg::BIT_BUSY] = busy;
						next_hrdata[sac_pkg::BIT_MODE_HI:sac_pkg::BIT_MODE_LO] =
							ctrl.startModeField;
						next_hrdata[sac_pkg::BIT_WINDOW_FLAG] = windowFlag;
					end
					default: begin
						next_hrdata = '0;
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			dphWrite <= 1'b0;
			dphAddr <= '0;
			hrdata <= '0;
		end else begin
			dphWrite <= next_dphWrite;
			dphAddr <= next_dphAddr;
			hrdata <= next_hrdata;
		end
	end

	// ==========================================================
	// register writes
	logic ctrlWrite, pairWrite;
	logic [2:0] wrMode;

	assign ctrlWrite = dphWrite && dphAddr == sac_pkg::ADDR_CONTROL;
	assign pairWrite = dphWrite && dphAddr == sac_pkg::ADDR_PAIR_CFG;
	assign wrMode = hwdata[sac_pkg::BIT_MODE_HI:sac_pkg::BIT_MODE_LO];

	always_comb begin
		next_ctrl = ctrl;
		next_pairDiff = pairDiff;
		if (ctrlWrite) begin
			next_ctrl.convEnable = hwdata[sac_pkg::BIT_CONV_ENABLE];
			next_ctrl.trackModeSel = hwdata[sac_pkg::BIT_TRACK_MODE];
			next_ctrl.startModeField = wrMode;
		end
		if (pairWrite) begin
			next_pairDiff = hwdata[sac_pkg::PAIR_COUNT-1:0];
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ctrl.convEnable <=
				sac_pkg::CONTROL_RESET[sac_pkg::BIT_CONV_ENABLE];
			ctrl.trackModeSel <=
				sac_pkg::CONTROL_RESET[sac_pkg::BIT_TRACK_MODE];
			ctrl.startModeField <= sac_pkg::CONTROL_RESET[
				sac_pkg::BIT_MODE_HI:sac_pkg::BIT_MODE_LO];
			pairDiff <= sac_pkg::PAIR_CFG_RESET[sac_pkg::PAIR_COUNT-1:0];
		end else begin
			ctrl <= next_ctrl;
			pairDiff <= next_pairDiff;
		end
	end

	// differential channels deliver signed results
	assign resultTwosComp = pairDiff[channelSel[2:1]];

	// ==========================================================
	// external start pin synchroniser
	logic extSync1, extSync2, extPrev, extRise;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			extSync1 <= 1'b0;
			extSync2 <= 1'b0;
			extPrev <= 1'b0;
		end else begin
			extSync1 <= extConvertStart;
			extSync2 <= extSync1;
			extPrev <= extSync2;
		end
	end

	assign extRise = extSync2 && !extPrev;

	// ==========================================================
	// sar clock enable divider
	logic [CNT_W-1:0] divCnt, next_divCnt;
	logic sarTick;

	// divider held at zero while disabled
	always_comb begin
		next_divCnt = divCnt + CNT_W'(1);
		if (!ctrl.convEnable || divCnt == DIV_LAST) begin
			next_divCnt = '0;
		end
	end

	assign sarTick = ctrl.convEnable && divCnt == DIV_LAST;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			divCnt <= '0;
		end else begin
			divCnt <= next_divCnt;
		end
	end

	// ==========================================================
	// start trigger selection
	logic swStart, trigger, mode1xx;

	// busy write uses the mode and enable written in the same access,
	// so a write that shuts the converter down never starts it
	assign swStart = ctrlWrite && hwdata[sac_pkg::BIT_BUSY] &&
		hwdata[sac_pkg::BIT_CONV_ENABLE] &&
		wrMode == sac_pkg::START_SOFTWARE;
	assign mode1xx = ctrl.startModeField[sac_pkg::BIT_START_COMPANION];

	always_comb begin
		trigger = 1'b0;
		if (mode1xx) begin
			trigger = companionBusyWrite;
		end else begin
			case (ctrl.startModeField)
				sac_pkg::START_TIMER3: begin
					trigger = timer3Overflow;
				end
				sac_pkg::START_EXT_PIN: begin
					trigger = extRise;
				end
				sac_pkg::START_TIMER2: begin
					trigger = timer2Overflow;
				end
				default: begin
					trigger = 1'b0;
				end
			endcase
		end
		if (swStart) begin
			trigger = 1'b1;
		end
	end

	// ==========================================================
	// conversion sequencer
	logic [CNT_W-1:0] sarCnt, next_sarCnt;
	logic pinTracked, convEnd;

	// pin-driven low-power mode has already tracked while the pin was low
	assign pinTracked = ctrl.startModeField == sac_pkg::START_EXT_PIN;
	assign convEnd = state == sac_pkg::SAC_CONVERT && sarTick &&
		sarCnt == CONV_LAST;

	always_comb begin
		next_state = state;
		next_sarCnt = sarCnt;
		case (state)
			sac_pkg::SAC_IDLE: begin
				next_sarCnt = '0;
				if (trigger && ctrl.convEnable) begin
					if (ctrl.trackModeSel && !pinTracked) begin
						next_state = sac_pkg::SAC_TRACK;
					end else begin
						next_state = sac_pkg::SAC_CONVERT;
					end
				end
			end
			sac_pkg::SAC_TRACK: begin
				if (sarTick) begin
					next_sarCnt = sarCnt + CNT_W'(1);
					if (sarCnt == TRACK_LAST) begin
						next_sarCnt = '0;
						next_state = sac_pkg::SAC_CONVERT;
					end
				end
			end
			sac_pkg::SAC_CONVERT: begin
				if (sarTick) begin
					next_sarCnt = sarCnt + CNT_W'(1);
				end
				if (convEnd) begin
					next_sarCnt = '0;
					next_state = sac_pkg::SAC_IDLE;
				end
			end
			default: begin
				next_state = sac_pkg::SAC_IDLE;
				next_sarCnt = '0;
			end
		endcase
		// clearing enable aborts without setting the done flag
		if (!ctrl.convEnable) begin
			next_state = sac_pkg::SAC_IDLE;
			next_sarCnt = '0;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state <= sac_pkg::SAC_IDLE;
			sarCnt <= '0;
		end else begin
			state <= next_state;
			sarCnt <= next_sarCnt;
		end
	end

	assign busy = state != sac_pkg::SAC_IDLE;

	// ==========================================================
	// sticky flags, hardware set wins over software clear
	logic doneClr, windowClr;

	// a written 0 clears a flag, a written 1 leaves it
	assign doneClr = ctrlWrite && !hwdata[sac_pkg::BIT_DONE_FLAG];
	assign windowClr = ctrlWrite && !hwdata[sac_pkg::BIT_WINDOW_FLAG];

	always_comb begin
		next_doneFlag = doneFlag;
		next_windowFlag = windowFlag;
		if (doneClr) begin
			next_doneFlag = 1'b0;
		end
		if (convEnd) begin
			next_doneFlag = 1'b1;
		end
		if (windowClr) begin
			next_windowFlag = 1'b0;
		end
		if (windowMatch) begin
			next_windowFlag = 1'b1;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			doneFlag <= 1'b0;
			windowFlag <= 1'b0;
			convDonePulse <= 1'b0;
		end else begin
			doneFlag <= next_doneFlag;
			windowFlag <= next_windowFlag;
			convDonePulse <= convEnd;
		end
	end

	// ==========================================================
	// analog control
	logic trackNow;

	always_comb begin
		trackNow = 1'b0;
		if (ctrl.convEnable) begin
			if (!ctrl.trackModeSel) begin
				trackNow = state != sac_pkg::SAC_CONVERT;
			end else if (state == sac_pkg::SAC_TRACK) begin
				trackNow = 1'b1;
			end else if (state == sac_pkg::SAC_IDLE && pinTracked) begin
				trackNow = !extSync2;
			end
		end
	end

	assign analog.powerUp = ctrl.convEnable;
	assign analog.track = trackNow;
	assign analog.convert = state == sac_pkg::SAC_CONVERT;
	assign analog.sarTick = sarTick;

endmodule

`default_nettype wire

// ===== common/sac_pkg.sv
`default_nettype none

package sac_pkg;

	// ==========================================================
	// register map (byte addresses on the bus)
	localparam logic [7:0] ADDR_PAIR_CFG = 8'h00;
	localparam logic [7:0] ADDR_CONTROL = 8'h04;
	localparam int ADDR_W = 8;

	// ==========================================================
	// reset values
	localparam logic [7:0] PAIR_CFG_RESET = 8'h00;
	localparam logic [7:0] CONTROL_RESET = 8'h00;

	// ==========================================================
	// control register field positions
	localparam int BIT_CONV_ENABLE = 7;
	localparam int BIT_TRACK_MODE = 6;
	localparam int BIT_DONE_FLAG = 5;
	localparam int BIT_BUSY = 4;
	localparam int BIT_MODE_HI = 3;
	localparam int BIT_MODE_LO = 1;
	localparam int BIT_WINDOW_FLAG = 0;
	localparam int PAIR_COUNT = 4;

	// ==========================================================
	// start-of-conversion sources
	localparam logic [2:0] START_SOFTWARE = 3'h0;
	localparam logic [2:0] START_TIMER3 = 3'h1;
	localparam logic [2:0] START_EXT_PIN = 3'h2;
	localparam logic [2:0] START_TIMER2 = 3'h3;
	localparam int BIT_START_COMPANION = 2;

	// ==========================================================
	// timing in sar clocks, sar clock divider in clk cycles
	localparam int TRACK_SAR_CLOCKS = 3;
	localparam int CONV_SAR_CLOCKS = 16;
	localparam int SAR_DIV_DEFAULT = 4;

	// ==========================================================
	// bus encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'h0;

	typedef enum {
		SAC_IDLE,
		SAC_TRACK,
		SAC_CONVERT
	} sac_state_e;

	typedef struct packed {
		logic convEnable;
		logic trackModeSel;
		logic [2:0] startModeField;
	} sac_ctrl_s;

	typedef struct packed {
		logic powerUp;
		logic track;
		logic convert;
		logic sarTick;
	} sac_analog_s;

endpackage

`default_nettype wire

// ===== dv/sac_conversion_control_props.sv
`timescale 1ns/10ps
`default_nettype none

module sac_conversion_control_props (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// watched outputs and channel select input
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic [2:0] channelSel,
	input wire logic resultTwosComp,
	input wire sac_pkg::sac_analog_s analog,
	input wire logic [sac_pkg::PAIR_COUNT-1:0] pairDiff,
	input wire logic convDonePulse
);
	// ==========================================================
	// properties
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	sequence sConvEnd;
		$fell(analog.convert) && analog.powerUp;
	endsequence
	sequence sHold;
		(analog.convert || !analog.powerUp) [*8];
	endsequence
	a_bus_okay: assert property (hreadyout && hresp == sac_pkg::HRESP_OKAY)
		else $error("bus not ready or not okay");
	a_off_idle: assert property (!analog.powerUp [*2] |->
		!analog.convert && !analog.track) else $error("active while off");
	a_track_excl: assert property (analog.track |->
		analog.powerUp && !analog.convert) else $error("track overlap");
	a_done_fall: assert property (sConvEnd |-> ##[0:1] convDonePulse)
		else $error("no done pulse at conversion end");
	a_done_cause: assert property (convDonePulse |->
		$past(analog.convert) || $past(analog.convert, 2))
		else $error("done pulse without conversion");
	a_conv_hold: assert property ($rose(analog.convert) |-> sHold)
		else $error("conversion cut short");
	a_twos_comp: assert property (
		resultTwosComp == pairDiff[channelSel[2:1]])
		else $error("format flag mismatch");
	a_rdata_upper: assert property (hrdata[31:8] == 24'h0)
		else $error("upper read bits set");
endmodule

bind sac_conversion_control sac_conversion_control_props i_props (
	.clk(clk), .reset(reset), .hreadyout(hreadyout), .hresp(hresp),
	.hrdata(hrdata), .channelSel(channelSel),
	.resultTwosComp(resultTwosComp), .analog(analog),
	.pairDiff(pairDiff), .convDonePulse(convDonePulse));

`default_nettype wire

// ===== dv/sac_trigger_model.sv
`timescale 1ns/10ps
`default_nettype none

module sac_trigger_model (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// bench command
	input wire logic fire,
	input wire logic [2:0] sel,
	input wire logic [3:0] lag,
	// trigger sources
	output logic timer3Overflow,
	output logic timer2Overflow,
	output logic companionBusyWrite,
	output logic extConvertStart
);
	// ==========================================================
	// delayed trigger, pin pulse
	logic [4:0] waitCnt;
	logic [3:0] pinCnt;
	logic [2:0] held;
	logic go;
	assign go = (waitCnt == 5'h01);
	assign timer3Overflow = go && held == 3'h1;
	assign timer2Overflow = go && held == 3'h3;
	assign companionBusyWrite = go && held[2];
	assign extConvertStart = (pinCnt != 4'h0);
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			waitCnt <= 5'h00;
			pinCnt <= 4'h0;
			held <= 3'h0;
		end else begin
			if (fire) begin
				waitCnt <= {1'h0, lag} + 5'h01;
				held <= sel;
			end else if (waitCnt != 5'h00)
				waitCnt <= waitCnt - 5'h01;
			if (go && held == 3'h2)
				pinCnt <= 4'hF;
			else if (pinCnt != 4'h0)
				pinCnt <= pinCnt - 4'h1;
		end
	end
endmodule

`default_nettype wire

// ===== dv/sac_conversion_control_tb.sv
`timescale 1ns/10ps
`default_nettype none

module sac_conversion_control_tb;
	// ==========================================================
	// bench signals
	logic clk = 1'h0;
	logic reset = 1'h1;
	logic hsel = 1'h0;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'h0;
	logic [31:0] hwdata = 32'h0;
	logic windowMatch = 1'h0;
	logic [2:0] channelSel = 3'h0;
	logic fire = 1'h0;
	logic [2:0] sel = 3'h0;
	logic [3:0] lag = 4'h0;
	logic hreadyout, hresp, resultTwosComp, convDonePulse;
	logic t3, t2, comp, ext;
	logic [31:0] hrdata, rd;
	logic [3:0] pairDiff;
	sac_pkg::sac_analog_s analog;
	int failCount = 0;
	int checks = 0;
	always #25 clk = ~clk;

	sac_conversion_control #(.SAR_DIV(1)) i_dut (.clk(clk), .reset(reset),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.timer3Overflow(t3), .timer2Overflow(t2), .companionBusyWrite(comp),
		.extConvertStart(ext), .windowMatch(windowMatch),
		.channelSel(channelSel), .resultTwosComp(resultTwosComp),
		.analog(analog), .pairDiff(pairDiff), .convDonePulse(convDonePulse));
	sac_trigger_model i_trig (.clk(clk), .reset(reset), .fire(fire),
		.sel(sel), .lag(lag), .timer3Overflow(t3), .timer2Overflow(t2),
		.companionBusyWrite(comp), .extConvertStart(ext));

	// ==========================================================
	// shared tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			failCount++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		hsel <= 1'h1;
		htrans <= sac_pkg::HTRANS_NONSEQ;
		haddr <= a;
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'h1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'h1);
		r = hrdata;
	endtask
	task automatic ctl(input logic [31:0] d);
		bus(1'h1, sac_pkg::ADDR_CONTROL, d, rd);
	endtask
	task automatic rdCtl();
		bus(1'h0, sac_pkg::ADDR_CONTROL, 32'h0, rd);
	endtask
	task automatic endSim();
		$display("checks %0d mismatches %0d", checks, failCount);
		if (failCount == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ==========================================================
	// scenarios
	task automatic tPair();
		bus(1'h0, sac_pkg::ADDR_PAIR_CFG, 32'h0, rd);
		chk(rd, 32'h0);
		rdCtl();
		chk(rd, 32'h0);
		bus(1'h1, sac_pkg::ADDR_PAIR_CFG, 32'hFF, rd);
		bus(1'h1, 8'h0C, 32'hFF, rd);
		bus(1'h0, 8'h08, 32'h0, rd);
		chk(rd, 32'h0);
		bus(1'h0, sac_pkg::ADDR_PAIR_CFG, 32'h0, rd);
		chk(rd, 32'h0F);
		bus(1'h1, sac_pkg::ADDR_PAIR_CFG, 32'h05, rd);
		@(posedge clk);
		chk(32'(pairDiff), 32'h5);
		for (int ch = 0; ch < 8; ch++) begin
			channelSel <= 3'(ch);
			@(posedge clk);
			chk(32'(resultTwosComp), 32'((5 >> (ch / 2)) & 1));
		end
	endtask
	task automatic tStart(input logic tm, input logic [2:0] mode);
		logic [7:0] c;
		int n;
		int k;
		c = {1'h1, tm, 2'h0, mode, 1'h0};
		n = 0;
		k = 0;
		ctl(32'(c));
		repeat (6) @(posedge clk);
		chk(32'(analog.track), 32'(!tm || mode == 3'h2));
		if (mode == sac_pkg::START_SOFTWARE)
			ctl(32'(c | 8'h10));
		else begin
			sel <= mode;
			lag <= 4'(mode);
			fire <= 1'h1;
			@(posedge clk);
			fire <= 1'h0;
		end
		while (analog.convert !== 1'h1 && k < 300) begin
			@(posedge clk);
			k++;
			n = n + 32'(analog.track && analog.sarTick);
		end
		chk(32'(k < 300), 32'h1);
		if (tm && mode != 3'h2)
			chk(32'(n), 32'(sac_pkg::TRACK_SAR_CLOCKS));
		rdCtl();
		chk(rd & 32'h10, 32'h10);
		k = 0;
		while (convDonePulse !== 1'h1 && k < 300) begin
			@(posedge clk);
			k++;
		end
		chk(32'(k < 300), 32'h1);
		repeat (20) @(posedge clk);
		rdCtl();
		chk(rd, 32'(c | 8'h20));
		ctl(32'(c));
		rdCtl();
		chk(rd, 32'(c));
	endtask
	task automatic tOff();
		ctl(32'h10);
		repeat (40) @(posedge clk);
		rdCtl();
		chk(rd, 32'h0);
		ctl(32'h92);
		repeat (40) @(posedge clk);
		rdCtl();
		chk(rd, 32'h82);
		ctl(32'h90);
		ctl(32'h10);
		repeat (40) @(posedge clk);
		rdCtl();
		chk(rd, 32'h0);
		windowMatch <= 1'h1;
		@(posedge clk);
		windowMatch <= 1'h0;
		repeat (10) @(posedge clk);
		rdCtl();
		chk(rd, 32'h01);
		ctl(32'h0);
		rdCtl();
		chk(rd, 32'h0);
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		failCount++;
		endSim();
	end
	initial begin
		repeat (12) @(posedge clk);
		reset <= 1'h0;
		@(posedge clk);
		tPair();
		for (int i = 0; i < 10; i++)
			tStart(1'(i / 5), 3'(i % 5));
		tOff();
		endSim();
	end
endmodule

`default_nettype wire
